// *** verilog/ext_bus_pkg.sv ***
// constants and types for the external memory bus interface
// Notes on behaviour
// R1 - address latch strobe pulses low once at start of every external cycle
// R2 - address, direction and space select valid before latch strobe rises
// R3 - software control floats both strobes, direction, both address buses
// R4 - write data on the muxed bus by the transfer strobe falling edge
// R5 - memory drives read data before transfer strobe rises; sampled there
// R6 - on-chip data cycles keep the transfer strobe high throughout
// R7 - direction low only for memory writes, high for everything else
// R8 - after reset read start vector from program bytes 00h, 01h, then fetch
// R9 - low address and data share eight bidirectional lines
// R10 - high address byte on eight dedicated output lines every cycle
// R11 - program/data space select output lets memory decode data space
// R12 - data 0 to 1FFh nonvolatile, 200h to 2FFh RAM, both internal
// R13 - every program fetch is an external program space cycle
// R14 - each space spans up to 65,536 bytes on a 16-bit address
// R15 - low address on muxed lines while latch strobe low, then released
// R16 - memory latches low address on latch strobe rise, drives only in read
package ext_bus_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_LO_ADDR  = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR  = 16'h0001;
  localparam logic [15:0] NVM_LAST     = 16'h01FF;
  localparam logic [15:0] RAM_FIRST    = 16'h0200;
  localparam logic [15:0] RAM_LAST     = 16'h02FF;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;

  // ---------------------------------------------------------------
  // cycle types
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_LATCH = 6'b000100,
    ST_XFER  = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_DONE  = 6'b100000
  } bus_state_type;

  typedef enum logic [2:0] {
    BT_VEC_LO = 3'b001,
    BT_VEC_HI = 3'b010,
    BT_USER   = 3'b100
  } boot_type;

endpackage : ext_bus_pkg

// *** verilog/ext_bus_req_if.sv ***
// request and answer signals between the bus sequencer and the boot stage
`timescale 1ns/1ns
interface ext_bus_req_if;
  logic        req;
  logic        space_data;
  logic        write;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  logic        internal;

  modport master (
    output req,
    output space_data,
    output write,
    output addr,
    output wdata,
    input  ack,
    input  rdata,
    input  internal
  );
  modport slave (
    input  req,
    input  space_data,
    input  write,
    input  addr,
    input  wdata,
    output ack,
    output rdata,
    output internal
  );
endinterface : ext_bus_req_if

// *** verilog/ext_bus_cycle.sv ***
// bus cycle sequencer driving the external memory pins
`timescale 1ns/1ns
module ext_bus_cycle
  import ext_bus_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  ext_bus_req_if.slave bus,
  input  wire logic  bus_float,
  input  wire logic [7:0] muxed_in,
  output logic [7:0] muxed_out,
  output logic       muxed_oe_n,
  output logic [7:0] upper_out,
  output logic       upper_oe_n,
  output logic       alstb_out,
  output logic       xfer_out,
  output logic       dir_out,
  output logic       space_out,
  output logic       ctl_oe_n
);

  bus_state_type state_q;
  logic          int_q;
  logic          wr_q;
  logic [7:0]    rdata_q;
  logic          ack_q;

  // on-chip data ranges
  function automatic logic is_internal(input logic d, input logic [15:0] a);
    is_internal = d && (a <= RAM_LAST); // R12
  endfunction : is_internal

  assign bus.ack      = ack_q;
  assign bus.rdata    = rdata_q;
  assign bus.internal = int_q;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      int_q     <= 1'b0;
      wr_q      <= 1'b0;
      rdata_q   <= 8'h00;
      ack_q     <= 1'b0;
      muxed_out <= 8'h00;
      muxed_oe_n <= 1'b1;
      upper_out <= 8'h00;
      alstb_out <= 1'b1;
      xfer_out  <= 1'b1;
      dir_out   <= 1'b1;
      space_out <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (bus.req && !bus_float) begin
            state_q    <= ST_ADDR;
            int_q      <= is_internal(bus.space_data, bus.addr);
            wr_q       <= bus.write;
            upper_out  <= bus.addr[15:8]; // R10 R14
            muxed_out  <= bus.addr[7:0]; // R9 R15
            muxed_oe_n <= 1'b0;
            dir_out    <= !bus.write; // R7
            space_out  <= bus.space_data; // R11 R13
            alstb_out  <= 1'b0; // R1
          end
        end
        ST_ADDR: begin
          state_q   <= ST_LATCH;
          alstb_out <= 1'b1; // R2 R16
        end
        ST_LATCH: begin
          state_q <= ST_XFER;
          if (wr_q) begin
            muxed_out <= bus.wdata; // R4
          end else begin
            muxed_oe_n <= 1'b1; // R15
          end
          xfer_out <= int_q; // R6
        end
        ST_XFER: begin
          state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          state_q  <= ST_DONE;
          xfer_out <= 1'b1;
          rdata_q  <= muxed_in; // R5
          ack_q    <= 1'b1;
        end
        ST_DONE: begin
          state_q    <= ST_IDLE;
          muxed_oe_n <= 1'b1;
          dir_out    <= 1'b1; // R7
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // float control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upper_oe_n <= 1'b1;
      ctl_oe_n   <= 1'b1;
    end else begin
      upper_oe_n <= bus_float && state_q == ST_IDLE; // R3
      ctl_oe_n   <= bus_float && state_q == ST_IDLE; // R3
    end
  end

endmodule : ext_bus_cycle

// *** verilog/ext_bus_top.sv ***
// external memory bus interface top with start vector boot
`timescale 1ns/1ns
module ext_bus_top
  import ext_bus_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        float_req,
  input  wire logic        core_req,
  input  wire logic        core_space_data,
  input  wire logic        core_write,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  output logic             core_ack,
  output logic [7:0]       core_rdata,
  output logic             core_internal,
  output logic             boot_done,
  output logic [15:0]      start_addr,
  input  wire logic [7:0]  muxed_addr_data_bus_in,
  output logic [7:0]       muxed_addr_data_bus_out,
  output logic             muxed_addr_data_bus_oe_n,
  output logic [7:0]       upper_addr_bus,
  output logic             upper_addr_bus_oe_n,
  output logic             addr_latch_strobe_n,
  output logic             transfer_strobe_n,
  output logic             read_not_write,
  output logic             space_data_sel,
  output logic             ctl_oe_n
);

  ext_bus_req_if bus ();
  boot_type   boot_q;
  logic       float_q;
  logic [7:0] vec_lo_q;
  logic       busy_q;

  // ---------------------------------------------------------------
  // boot vector fetch and request mux
  // ---------------------------------------------------------------
  assign bus.req        = (boot_q != BT_USER) ? !busy_q : core_req && !busy_q;
  assign bus.space_data = (boot_q != BT_USER) ? 1'b0 : core_space_data;
  assign bus.write      = (boot_q != BT_USER) ? 1'b0 : core_write;
  assign bus.addr       = (boot_q == BT_VEC_LO) ? VEC_LO_ADDR : // R8
                          (boot_q == BT_VEC_HI) ? VEC_HI_ADDR : core_addr;
  assign bus.wdata      = core_wdata;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      float_q <= 1'b0;
    end else begin
      float_q <= float_req; // R3
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      boot_q     <= BT_VEC_LO;
      busy_q     <= 1'b0;
      vec_lo_q   <= 8'h00;
      start_addr <= 16'h0000;
      boot_done  <= 1'b0;
      core_ack   <= 1'b0;
      core_rdata <= 8'h00;
      core_internal <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (bus.req && !float_q) begin
        busy_q <= 1'b1;
      end
      if (bus.ack) begin
        busy_q <= 1'b0;
        unique case (boot_q)
          BT_VEC_LO: begin
            vec_lo_q <= bus.rdata;
            boot_q   <= BT_VEC_HI;
          end
          BT_VEC_HI: begin
            start_addr <= {bus.rdata, vec_lo_q}; // R8
            boot_done  <= 1'b1;
            boot_q     <= BT_USER;
          end
          BT_USER: begin
            core_ack      <= 1'b1;
            core_rdata    <= bus.rdata;
            core_internal <= bus.internal;
          end
          default: boot_q <= BT_USER;
        endcase
      end
    end
  end

  ext_bus_cycle u_cycle (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .bus        (bus.slave),
    .bus_float  (float_q),
    .muxed_in   (muxed_addr_data_bus_in),
    .muxed_out  (muxed_addr_data_bus_out),
    .muxed_oe_n (muxed_addr_data_bus_oe_n),
    .upper_out  (upper_addr_bus),
    .upper_oe_n (upper_addr_bus_oe_n),
    .alstb_out  (addr_latch_strobe_n),
    .xfer_out   (transfer_strobe_n),
    .dir_out    (read_not_write),
    .space_out  (space_data_sel),
    .ctl_oe_n   (ctl_oe_n)
  );

endmodule : ext_bus_top

// *** test/ext_mem_model.sv ***
// external program and data memory with its address latch
`timescale 1ns/1ns
module ext_mem_model #(
  parameter logic [15:0] VEC = 16'h0000
) (
  input  wire logic       als_n,
  input  wire logic       xs_n,
  input  wire logic       rnw,
  input  wire logic       dsel,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] lo,
  input  wire logic       oe_n,
  output      logic [7:0] din
);
  logic [7:0]  mem [0:131071];
  logic [16:0] lat;
  logic [7:0]  last;
  initial begin
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'h5A;
    mem[17'h00000] = VEC[7:0];
    mem[17'h00001] = VEC[15:8];
    lat = 17'h00000;
    last = 8'h00;
  end
  always @(posedge als_n) lat = {dsel, hi, lo};
  always @(posedge xs_n) begin
    if (!rnw)
      mem[lat] = lo;
    last = din;
  end
  always @* begin
    if (!oe_n)
      din = lo;
    else if (!xs_n && rnw)
      din = mem[lat];
    else
      din = ~last;
  end
endmodule : ext_mem_model

// *** test/ext_bus_top_assertions.sv ***
// pin timing checks for the external memory bus interface
`timescale 1ns/1ns
module ext_bus_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic core_ack,
  input wire logic core_internal,
  input wire logic muxed_addr_data_bus_oe_n,
  input wire logic upper_addr_bus_oe_n,
  input wire logic addr_latch_strobe_n,
  input wire logic transfer_strobe_n,
  input wire logic read_not_write,
  input wire logic ctl_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  AST_ALS_ONE: assert property ($fell(addr_latch_strobe_n) |=>
    addr_latch_strobe_n) else $error("address strobe too long");
  AST_XFER_LATE: assert property ($fell(transfer_strobe_n) |->
    !$past(addr_latch_strobe_n, 2)) else $error("early transfer");
  AST_INT_QUIET: assert property (core_ack && core_internal |->
    $past(transfer_strobe_n, 2) && $past(transfer_strobe_n, 3))
    else $error("transfer on internal cycle");
  AST_EXT_XFER: assert property (core_ack && !core_internal |->
    !$past(transfer_strobe_n, 2) && !$past(transfer_strobe_n, 3))
    else $error("no transfer");
  AST_DIR_START: assert property ($fell(read_not_write) |->
    !addr_latch_strobe_n) else $error("direction late");
  AST_DIR_HELD: assert property (!addr_latch_strobe_n |=>
    $stable(read_not_write)) else $error("direction moved");
  AST_READ_FREE: assert property (!transfer_strobe_n &&
    read_not_write |-> muxed_addr_data_bus_oe_n) else $error("bus clash");
  AST_ADDR_OUT: assert property (!addr_latch_strobe_n |->
    !muxed_addr_data_bus_oe_n && !upper_addr_bus_oe_n)
    else $error("address not driven");
  AST_FLOAT_ALL: assert property (ctl_oe_n |->
    muxed_addr_data_bus_oe_n && upper_addr_bus_oe_n)
    else $error("partial float");
endmodule : ext_bus_checker
bind ext_bus_top ext_bus_checker u_chk (.clk_sys, .rst_b, .core_ack,
  .core_internal, .muxed_addr_data_bus_oe_n, .upper_addr_bus_oe_n,
  .addr_latch_strobe_n, .transfer_strobe_n, .read_not_write, .ctl_oe_n);

// *** test/ext_bus_top_bench.sv ***
// self-checking bench for the external memory bus interface
`timescale 1ns/1ns
module ext_bus_top_bench import ext_bus_pkg::*;;
  localparam logic [15:0] VEC = 16'h1234;
  logic clk_sys, rst_b, float_req, core_req, core_space_data, core_write;
  logic [15:0] core_addr, start_addr;
  logic [7:0] core_wdata, core_rdata, upper_addr_bus, rd;
  logic [7:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out;
  logic core_ack, core_internal, boot_done, ri, ctl_oe_n;
  logic muxed_addr_data_bus_oe_n, upper_addr_bus_oe_n, read_not_write;
  logic addr_latch_strobe_n, transfer_strobe_n, space_data_sel;
  int mismatches, samples_checked;
  ext_bus_top u_dut (.clk_sys, .rst_b, .float_req, .core_req,
    .core_space_data, .core_write, .core_addr, .core_wdata, .core_ack,
    .core_rdata, .core_internal, .boot_done, .start_addr,
    .muxed_addr_data_bus_in, .muxed_addr_data_bus_out,
    .muxed_addr_data_bus_oe_n, .upper_addr_bus, .upper_addr_bus_oe_n,
    .addr_latch_strobe_n, .transfer_strobe_n, .read_not_write,
    .space_data_sel, .ctl_oe_n);
  ext_mem_model #(.VEC(VEC)) u_mem (.als_n(addr_latch_strobe_n),
    .xs_n(transfer_strobe_n), .rnw(read_not_write), .dsel(space_data_sel),
    .hi(upper_addr_bus), .lo(muxed_addr_data_bus_out),
    .oe_n(muxed_addr_data_bus_oe_n), .din(muxed_addr_data_bus_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task acc(input logic d, input logic w, input logic [15:0] a,
           input logic [7:0] wd);
    int n;
    @(negedge clk_sys);
    {core_space_data, core_write, core_addr, core_wdata} = {d, w, a, wd};
    core_req = 1'b1;
    n = 0;
    while (core_ack !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (addr_latch_strobe_n === 1'b0) begin
        chk({upper_addr_bus, muxed_addr_data_bus_out}, a);
        chk(16'({space_data_sel, read_not_write}), 16'({d, !w}));
      end
      if (w && transfer_strobe_n === 1'b0)
        chk(16'(muxed_addr_data_bus_out), 16'(wd));
      if (d && a <= RAM_LAST)
        chk(16'(transfer_strobe_n), 16'h0001);
    end
    chk(16'(core_ack), 16'h0001);
    rd = core_rdata;
    ri = core_internal;
    @(negedge clk_sys);
    core_req = 1'b0;
  endtask : acc
  task results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task t_ext;
    acc(1'b1, 1'b1, 16'h8000, 8'hA5);
    acc(1'b1, 1'b0, 16'h8000, 8'h00);
    chk(16'({ri, rd}), 16'h00A5);
    acc(1'b0, 1'b1, 16'hFFFF, 8'h3C);
    acc(1'b0, 1'b0, 16'hFFFF, 8'h00);
    chk(16'({ri, rd}), 16'h003C);
    $display("external test done");
  endtask : t_ext
  task t_int;
    logic [15:0] tab [5];
    tab = '{16'h0000, NVM_LAST, RAM_FIRST, RAM_LAST, 16'h0300};
    foreach (tab[i]) begin
      acc(1'b1, 1'b0, tab[i], 8'h00);
      chk(16'(ri), 16'(tab[i] <= RAM_LAST));
    end
    acc(1'b0, 1'b0, 16'h0100, 8'h00);
    chk(16'(ri), 16'h0000);
    $display("internal test done");
  endtask : t_int
  task t_float;
    @(negedge clk_sys);
    float_req = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'({ctl_oe_n, upper_addr_bus_oe_n, muxed_addr_data_bus_oe_n}),
        16'h0007);
    fork
      acc(1'b1, 1'b0, 16'h8000, 8'h00);
      begin
        repeat (10) begin
          @(posedge clk_sys);
          #1;
          chk(16'(core_ack), 16'h0000);
        end
        @(negedge clk_sys);
        float_req = 1'b0;
      end
    join
    chk(16'(rd), 16'h00A5);
    $display("float test done");
  endtask : t_float
  task t_boot;
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(start_addr, VEC);
    chk(16'(boot_done), 16'h0001);
    $display("boot test done");
  endtask : t_boot
  initial begin
    {rst_b, float_req, core_req, core_space_data, core_write} = 5'h00;
    {core_addr, core_wdata} = 24'h000000;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    t_boot;
    t_ext;
    t_int;
    t_float;
    results;
  end
  initial begin
    #50000;
    mismatches++;
    results;
  end
endmodule : ext_bus_top_bench
